/* File: dv/lds_diag_status_bench.sv */
// self-checking bench of the diagnostic status block.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module lds_diag_status_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dim_input_1 = 1'b0, dim_input_2 = 1'b0, dim_input_3 = 1'b0;
  logic [2:0] current_hit_live = 3'h0, headroom_low = 3'h0, seen_clr = 3'h0;
  logic input_supply_above = 1'b1, overtemp_det = 1'b0;
  logic gate_supply_at_target = 1'b1, enable_in = 1'b1;
  wire acc_stb, acc_wr, acc_cnt_bad, ext_map_ok, ext_ro, rd_valid_ff, wr_accept_ff;
  wire rd_fault_ret_ff, gate_reg_en_ff, gate_drive_en_ff, vled_update_en_ff, clr_req_ff;
  wire [6:0] acc_addr;
  wire [7:0] acc_wdata, ext_rdata, rd_data_ff, rd_data2_ff;
  wire [2:0] current_hit_clear_ff;
  int n_mismatch = 0;
  int n_checks = 0;
  lds_diag_status #(.ERR_STARTUP_CYC(40), .ERR_OPER_CYC(8)) i_lds_diag_status (
    .clk_sys, .rst_n, .acc_stb, .acc_wr, .acc_addr, .acc_wdata, .acc_cnt_bad,
    .ext_map_ok, .ext_ro, .ext_rdata, .dim_input_1, .dim_input_2, .dim_input_3,
    .current_hit_live, .headroom_low, .input_supply_above, .overtemp_det,
    .gate_supply_at_target, .enable_in, .rd_valid_ff, .rd_data_ff, .rd_data2_ff,
    .rd_fault_ret_ff, .wr_accept_ff, .gate_reg_en_ff, .gate_drive_en_ff,
    .vled_update_en_ff, .current_hit_clear_ff, .clr_req_ff
  );
  lds_host_model i_lds_host_model (
    .clk_sys, .rd_fault_ret_ff, .acc_stb, .acc_wr, .acc_addr, .acc_wdata,
    .acc_cnt_bad, .ext_map_ok, .ext_ro, .ext_rdata
  );
  // clock and live-hit clear pulse catcher
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) seen_clr <= seen_clr | current_hit_clear_ff;
  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string what);
    i_lds_host_model.access(1'b0, a, 8'h00, 1'b0, 1'b0);
    chk(what, rd_data_ff, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic bad, input logic ro);
    i_lds_host_model.access(1'b1, a, d, bad, ro);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // watchdog
  initial
  begin
    #8000;
    n_mismatch++;
    finish_test();
  end
  // main sequence
  initial
  begin
    pause(2);
    rst_n <= 1'b1;
    pause(10);
    rdchk(7'h37, 8'h88, "status up");
    chk("drive", {7'h00, gate_drive_en_ff}, 8'h01);
    chk("vled", {7'h00, vled_update_en_ff}, 8'h01);
    current_hit_live <= 3'h1;
    dim_input_1 <= 1'b1;
    pause(6);
    dim_input_1 <= 1'b0;
    pause(6);
    rdchk(7'h36, 8'h41, "toggle");
    rdchk(7'h37, 8'h89, "hit fall");
    wr(7'h36, 8'h00, 1'b0, 1'b0);
    rdchk(7'h36, 8'h40, "toggle clr");
    current_hit_live <= 3'h2;
    wr(7'h06, 8'h02, 1'b0, 1'b0);
    pause(3);
    rdchk(7'h37, 8'h8B, "refresh");
    rdchk(7'h06, 8'h00, "refresh self clr");
    chk("hit clr", {5'h00, seen_clr}, 8'h02);
    headroom_low <= 3'h1;
    pause(6);
    rdchk(7'h37, 8'h8A, "headroom");
    headroom_low <= 3'h0;
    dim_input_2 <= 1'b1;
    pause(6);
    wr(7'h36, 8'hFF, 1'b1, 1'b0);
    rdchk(7'h06, 8'hCA, "forced status");
    chk("forced toggle", rd_data2_ff, 8'h42);
    wr(7'h37, 8'h00, 1'b0, 1'b0);
    rdchk(7'h37, 8'h8A, "fault clr");
    rdchk(7'h00, 8'h5A, "foreign read");
    rdchk(7'h10, 8'h00, "reserved");
    rdchk(7'h06, 8'hCA, "reserved fault");
    chk("dropped", {7'h00, i_lds_host_model.dropped}, 8'h01);
    wr(7'h30, 8'h01, 1'b0, 1'b1);
    rdchk(7'h06, 8'hCA, "ro fault");
    chk("ret flag", {7'h00, rd_fault_ret_ff}, 8'h01);
    wr(7'h37, 8'h00, 1'b0, 1'b0);
    input_supply_above <= 1'b0;
    pause(6);
    rdchk(7'h37, 8'h00, "uv");
    chk("uv gate", {gate_reg_en_ff, vled_update_en_ff}, 8'h00);
    input_supply_above <= 1'b1;
    pause(8);
    rdchk(7'h37, 8'h88, "uv back");
    overtemp_det <= 1'b1;
    pause(6);
    rdchk(7'h37, 8'hB0, "overtemp");
    chk("ot drive", {7'h00, gate_drive_en_ff}, 8'h00);
    overtemp_det <= 1'b0;
    pause(6);
    wr(7'h00, 8'h40, 1'b0, 1'b0);
    pause(8);
    rdchk(7'h37, 8'h88, "err clr");
    chk("clr req", {7'h00, clr_req_ff}, 8'h00);
    gate_supply_at_target <= 1'b0;
    pause(16);
    rdchk(7'h37, 8'h90, "gs timeout");
    chk("gs vled", {7'h00, vled_update_en_ff}, 8'h00);
    enable_in <= 1'b0;
    pause(6);
    rdchk(7'h37, 8'h80, "off clr");
    finish_test();
  end
endmodule // lds_diag_status_bench
`default_nettype wire

/* File: dv/lds_diag_status_checker.sv */
// assertions on access answers and power-stage enables of the status block.
// assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lds_diag_status_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // access request
  input wire logic acc_stb,
  input wire logic acc_wr,
  input wire logic [6:0] acc_addr,
  input wire logic acc_cnt_bad,
  // answer and control
  input wire logic rd_valid_ff,
  input wire logic rd_fault_ret_ff,
  input wire logic wr_accept_ff,
  input wire logic gate_reg_en_ff,
  input wire logic gate_drive_en_ff,
  input wire logic vled_update_en_ff,
  input wire logic clr_req_ff
);
  logic pend_ff;
  wire good_wr = acc_stb && acc_wr && !acc_cnt_bad;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // remembers a frame fault from a bad clock count until the next access
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      pend_ff <= 1'b0;
    else if (acc_stb)
      pend_ff <= acc_cnt_bad;
  answer_pulse_a: assert property (rd_valid_ff == $past(acc_stb))
    else $error("answer pulse not one cycle after access");
  bad_wr_drop_a: assert property (acc_stb && acc_wr && acc_cnt_bad |=> !wr_accept_ff)
    else $error("faulted write accepted");
  read_no_wr_a: assert property (acc_stb && !acc_wr |=> !wr_accept_ff)
    else $error("read taken as write");
  status_wr_a: assert property (good_wr && acc_addr == 7'h37 |=> wr_accept_ff)
    else $error("status write refused");
  toggle_wr_a: assert property (good_wr && acc_addr == 7'h36 |=> wr_accept_ff)
    else $error("toggle write refused");
  fault_ret_a: assert property (acc_stb && pend_ff |=> rd_fault_ret_ff)
    else $error("no forced status after frame fault");
  drive_reg_a: assert property (gate_drive_en_ff |-> gate_reg_en_ff)
    else $error("gate drive on without regulator");
  vled_stop_a: assert property ($fell(gate_reg_en_ff) |-> ##[0:2] !vled_update_en_ff)
    else $error("measurement update kept after gate stop");
  cover property (acc_stb && pend_ff);
  cover property ($rose(clr_req_ff));
  cover property (wr_accept_ff);
endmodule // lds_diag_status_checker
bind lds_diag_status lds_diag_status_checker i_lds_diag_status_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .acc_stb(acc_stb), .acc_wr(acc_wr),
  .acc_addr(acc_addr), .acc_cnt_bad(acc_cnt_bad), .rd_valid_ff(rd_valid_ff),
  .rd_fault_ret_ff(rd_fault_ret_ff), .wr_accept_ff(wr_accept_ff),
  .gate_reg_en_ff(gate_reg_en_ff), .gate_drive_en_ff(gate_drive_en_ff),
  .vled_update_en_ff(vled_update_en_ff), .clr_req_ff(clr_req_ff)
);
`default_nettype wire

/* File: dv/lds_host_model.sv */
// controller model: issues one decoded access per call.
// assumes the answer flops load at the taking edge itself.
`timescale 1ns/10ps
`default_nettype none
module lds_host_model (
  // clock
  input wire logic clk_sys,
  // answer flag
  input wire logic rd_fault_ret_ff,
  // access request
  output var logic acc_stb = 1'b0,
  output var logic acc_wr = 1'b0,
  output var logic [6:0] acc_addr = 7'h00,
  output var logic [7:0] acc_wdata = 8'h00,
  output var logic acc_cnt_bad = 1'b0,
  // foreign address map stand-in
  output var logic ext_map_ok = 1'b0,
  output var logic ext_ro = 1'b0,
  output var logic [7:0] ext_rdata = 8'h5A
);
  logic dropped = 1'b0;
  // one access, held until its taking edge, then strobe dropped and address and data inverted
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                        input logic bad, input logic ro);
    @(posedge clk_sys);
    acc_stb <= 1'b1;
    acc_wr <= w;
    acc_addr <= a;
    acc_wdata <= d;
    acc_cnt_bad <= bad;
    ext_map_ok <= (a == 7'h00) || ro;
    ext_ro <= ro;
    @(posedge clk_sys);
    acc_stb <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    // answer flops load at the taking edge; read them settled one edge later
    @(posedge clk_sys);
    // a forced answer means the earlier read's data must be dropped
    dropped = (rd_fault_ret_ff === 1'b1);
  endtask
endmodule // lds_host_model
`default_nettype wire

/* File: rtl/lds_diag_status.v */
// diagnostic status logic of a three-channel led driver: supply, thermal
// and gate-supply faults, frame fault tracking, current-hit and toggle flags.
// assumes an spi framer delivering one decoded access per acc_stb pulse,
// and that the rest of the device reports mapping of foreign addresses.
`timescale 1ns/10ps
`default_nettype none
`include "lds_diag_status_defines.vh"

module lds_diag_status #(
  parameter ERR_STARTUP_CYC =
    (`LDS_T_ERR_STARTUP_NS + `LDS_CLK_PERIOD_NS - 1) / `LDS_CLK_PERIOD_NS,
  parameter ERR_OPER_CYC =
    (`LDS_T_ERR_OPER_NS + `LDS_CLK_PERIOD_NS - 1) / `LDS_CLK_PERIOD_NS
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // decoded register access from the spi framer
  input wire acc_stb,
  input wire acc_wr,
  input wire [`LDS_ADDR_W-1:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire acc_cnt_bad,
  // mapping of addresses owned by the rest of the device
  input wire ext_map_ok,
  input wire ext_ro,
  input wire [7:0] ext_rdata,
  // asynchronous pins and analog comparators
  input wire dim_input_1,
  input wire dim_input_2,
  input wire dim_input_3,
  input wire [2:0] current_hit_live,
  input wire [2:0] headroom_low,
  input wire input_supply_above,
  input wire overtemp_det,
  input wire gate_supply_at_target,
  input wire enable_in,
  // read answer
  output reg rd_valid_ff,
  output reg [7:0] rd_data_ff,
  output reg [7:0] rd_data2_ff,
  output reg rd_fault_ret_ff,
  output reg wr_accept_ff,
  // control toward the power stage
  output reg gate_reg_en_ff,
  output reg gate_drive_en_ff,
  output reg vled_update_en_ff,
  output reg [2:0] current_hit_clear_ff,
  output reg clr_req_ff
);

  localparam CW = `LDS_ERR_CNT_W;
  // limits worked out at integer width, then cut to the counter width on purpose
  localparam integer STARTUP_LIM_I = ERR_STARTUP_CYC - 1;
  localparam integer OPER_LIM_I = ERR_OPER_CYC - 1;
  localparam [CW-1:0] STARTUP_LIM = STARTUP_LIM_I[CW-1:0];
  localparam [CW-1:0] OPER_LIM = OPER_LIM_I[CW-1:0];

  wire [`LDS_SYNC_W-1:0] sync_out;
  wire [2:0] dim_s;
  wire [2:0] hit_s;
  wire [2:0] lv_s;
  wire uv_ok_s;
  wire ot_s;
  wire reg_ok_s;
  wire en_s;

  reg [2:0] dim_prev_ff;
  reg [2:0] lv_prev_ff;
  reg supply_good_flag_ff;
  reg spi_fault_ff;
  reg fault_ret_ff;
  reg overtemp_flag_ff;
  reg gate_supply_fault_ff;
  reg gsf_with_ot_ff;
  reg gate_supply_good_ff;
  reg started_ff;
  reg [CW-1:0] err_cnt_ff;
  reg [2:0] current_hit_last_ff;
  reg [2:0] current_hit_refresh_ff;
  reg [2:0] toggle_ff;

  // asynchronous inputs pass two flops before any logic
  lds_sync #(
    .W(`LDS_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({enable_in, gate_supply_at_target, overtemp_det, input_supply_above,
          headroom_low, current_hit_live, dim_input_3, dim_input_2, dim_input_1}),
    .dout(sync_out)
  );

  assign dim_s = sync_out[2:0];
  assign hit_s = sync_out[5:3];
  assign lv_s = sync_out[8:6];
  assign uv_ok_s = sync_out[9];
  assign ot_s = sync_out[10];
  assign reg_ok_s = sync_out[11];
  assign en_s = sync_out[12];

  // address decode and frame fault detection
  wire sel_refresh = (acc_addr == `LDS_ADDR_HIT_REFRESH);
  wire sel_toggle = (acc_addr == `LDS_ADDR_TOGGLE);
  wire sel_status = (acc_addr == `LDS_ADDR_STATUS);
  wire sel_func = (acc_addr == `LDS_ADDR_FUNC_CTRL);
  wire sel_own = sel_refresh | sel_toggle | sel_status;
  wire addr_rsvd = !sel_own && !ext_map_ok;
  wire addr_ro = !sel_own && ext_ro;
  wire frame_err = acc_stb && (acc_cnt_bad || (acc_wr && (addr_rsvd || addr_ro)) ||
                   (!acc_wr && addr_rsvd));
  wire wr_ok = acc_stb && acc_wr && !frame_err;
  wire wr_refresh = wr_ok && sel_refresh;
  wire wr_toggle = wr_ok && sel_toggle;
  wire wr_status = wr_ok && sel_status;
  wire wr_func = wr_ok && sel_func;

  // readable images of the own registers
  wire [7:0] status_img = {supply_good_flag_ff, spi_fault_ff, overtemp_flag_ff,
                           gate_supply_fault_ff, gate_supply_good_ff,
                           current_hit_last_ff};
  wire [7:0] toggle_img = {`LDS_TOGGLE_RSVD, toggle_ff};
  wire [7:0] refresh_img = {`LDS_REFRESH_RSVD, current_hit_refresh_ff};

  // supply, thermal and gate supply state
  wire uv_fall = supply_good_flag_ff && !uv_ok_s;
  wire run = supply_good_flag_ff && en_s && !overtemp_flag_ff &&
             !gate_supply_fault_ff;
  wire clr_act = clr_req_ff && (overtemp_flag_ff || gate_supply_fault_ff);
  wire ot_clear = clr_act && overtemp_flag_ff && !ot_s;
  wire [CW-1:0] err_lim = started_ff ? OPER_LIM : STARTUP_LIM;
  wire gs_timeout = run && !reg_ok_s && (err_cnt_ff == err_lim);
  wire ot_gs_set = ot_s && gate_supply_good_ff;
  wire gs_set = gs_timeout || ot_gs_set;
  wire gs_clear = clr_act || !en_s || (ot_clear && gsf_with_ot_ff);

  reg nxt_spi_fault;
  reg nxt_fault_ret;
  reg nxt_overtemp;
  reg nxt_gs_fault;
  reg nxt_gsf_with_ot;
  reg nxt_gs_good;
  reg nxt_clr_req;
  reg [CW-1:0] nxt_err_cnt;

  // next state of the fault flags; an arriving event beats its clear
  always @*
  begin
    nxt_spi_fault = frame_err || (spi_fault_ff && !wr_status);
    nxt_fault_ret = frame_err || (fault_ret_ff && !acc_stb);
    nxt_overtemp = ot_s || (overtemp_flag_ff && !clr_act);
    nxt_gs_fault = gs_set || (gate_supply_fault_ff && !gs_clear);
    nxt_gsf_with_ot = ot_gs_set || (gsf_with_ot_ff && !gs_clear);
    nxt_gs_good = run && reg_ok_s && !gs_set;
    nxt_clr_req = (wr_func && acc_wdata[`LDS_FC_CLR_REQ]) ||
                  (clr_req_ff && !clr_act);
    if (run && !reg_ok_s && !gs_timeout)
      nxt_err_cnt = err_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    else
      nxt_err_cnt = {CW{1'b0}};
  end

  // per-channel hit, refresh and toggle logic
  wire [2:0] nxt_hit_last;
  wire [2:0] nxt_refresh;
  wire [2:0] nxt_toggle;
  genvar ch;
  generate
    for (ch = 0; ch < `LDS_NCH; ch = ch + 1)
    begin : g_ch
      wire dim_fall = dim_prev_ff[ch] && !dim_s[ch];
      wire lv_rise = lv_s[ch] && !lv_prev_ff[ch];
      assign nxt_hit_last[ch] = (uv_fall || lv_rise) ? 1'b0 :
        ((dim_fall || current_hit_refresh_ff[ch]) ? hit_s[ch] :
        current_hit_last_ff[ch]);
      assign nxt_refresh[ch] = wr_refresh && acc_wdata[ch];
      assign nxt_toggle[ch] = (dim_s[ch] ^ dim_prev_ff[ch]) ||
        (toggle_ff[ch] && !wr_toggle);
    end
  endgenerate

  // state registers
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dim_prev_ff <= 3'h0;
      lv_prev_ff <= 3'h0;
      supply_good_flag_ff <= 1'b0;
      spi_fault_ff <= 1'b0;
      fault_ret_ff <= 1'b0;
      overtemp_flag_ff <= 1'b0;
      gate_supply_fault_ff <= 1'b0;
      gsf_with_ot_ff <= 1'b0;
      gate_supply_good_ff <= 1'b0;
      started_ff <= 1'b0;
      err_cnt_ff <= {CW{1'b0}};
      current_hit_last_ff <= 3'h0;
      current_hit_refresh_ff <= 3'h0;
      toggle_ff <= 3'h0;
      clr_req_ff <= 1'b0;
    end
    else
    begin
      dim_prev_ff <= dim_s;
      lv_prev_ff <= lv_s;
      supply_good_flag_ff <= uv_ok_s;
      spi_fault_ff <= nxt_spi_fault;
      fault_ret_ff <= nxt_fault_ret;
      overtemp_flag_ff <= nxt_overtemp;
      gate_supply_fault_ff <= nxt_gs_fault;
      gsf_with_ot_ff <= nxt_gsf_with_ot;
      gate_supply_good_ff <= nxt_gs_good;
      started_ff <= run && (started_ff || gate_supply_good_ff);
      err_cnt_ff <= nxt_err_cnt;
      current_hit_last_ff <= nxt_hit_last;
      current_hit_refresh_ff <= nxt_refresh;
      toggle_ff <= nxt_toggle;
      clr_req_ff <= nxt_clr_req;
    end
  end

  // power stage control
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_reg_en_ff <= 1'b0;
      gate_drive_en_ff <= 1'b0;
      vled_update_en_ff <= 1'b0;
      current_hit_clear_ff <= 3'h0;
    end
    else
    begin
      gate_reg_en_ff <= run;
      gate_drive_en_ff <= run && gate_supply_good_ff;
      vled_update_en_ff <= supply_good_flag_ff && gate_supply_good_ff &&
                           !gate_supply_fault_ff;
      current_hit_clear_ff <= current_hit_refresh_ff;
    end
  end

  // read answer and write acceptance
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= `LDS_RD_ZERO;
      rd_data2_ff <= `LDS_RD_ZERO;
      rd_fault_ret_ff <= 1'b0;
      wr_accept_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= acc_stb;
      wr_accept_ff <= wr_ok;
      if (acc_stb)
      begin
        rd_fault_ret_ff <= fault_ret_ff;
        if (fault_ret_ff)
        begin
          rd_data_ff <= status_img;
          rd_data2_ff <= toggle_img;
        end
        else
        begin
          rd_data2_ff <= `LDS_RD_ZERO;
          if (sel_status)
            rd_data_ff <= status_img;
          else if (sel_toggle)
            rd_data_ff <= toggle_img;
          else if (sel_refresh)
            rd_data_ff <= refresh_img;
          else if (addr_rsvd)
            rd_data_ff <= `LDS_RD_ZERO;
          else
            rd_data_ff <= ext_rdata;
        end
      end
    end
  end

endmodule // lds_diag_status

`default_nettype wire

/* File: rtl/lds_diag_status_defines.vh */
// constants of the diagnostic status block: addresses, bit positions,
// reserved read values and error timing.
// assumes an 8-bit register space with 7-bit addresses and a 4 ns clock.
`ifndef LDS_DIAG_STATUS_DEFINES_VH
`define LDS_DIAG_STATUS_DEFINES_VH

// register addresses
`define LDS_ADDR_W 7
`define LDS_ADDR_FUNC_CTRL 7'h00
`define LDS_ADDR_HIT_REFRESH 7'h06
`define LDS_ADDR_TOGGLE 7'h36
`define LDS_ADDR_STATUS 7'h37

// operating_status bit positions
`define LDS_ST_SUPPLY_GOOD 7
`define LDS_ST_SPI_FAULT 6
`define LDS_ST_OVERTEMP 5
`define LDS_ST_GS_FAULT 4
`define LDS_ST_GS_GOOD 3

// function control: fault-clear request bit
`define LDS_FC_CLR_REQ 6

// channel count and synchroniser width
`define LDS_NCH 3
`define LDS_SYNC_W 13

// fixed read values of reserved bits
`define LDS_TOGGLE_RSVD 5'h08
`define LDS_REFRESH_RSVD 5'h00
`define LDS_RD_ZERO 8'h00

// error timing
`define LDS_CLK_PERIOD_NS 4
`define LDS_T_ERR_STARTUP_NS 1000000
`define LDS_T_ERR_OPER_NS 100000
`define LDS_ERR_CNT_W 20

`endif

/* File: rtl/lds_sync.v */
// two-flop synchroniser bank for asynchronous status and pin inputs.
// assumes inputs are levels that stay stable for at least two clocks.
`timescale 1ns/10ps
`default_nettype none

module lds_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // asynchronous in, synchronous out
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule // lds_sync

`default_nettype wire
